// ### inc/cca_pkg.sv
/*
  Constants for the compare/capture channel control block.
  Assumes a 32-bit APB slave with byte addresses, one register per word.
*/
package cca_pkg;
  localparam int NUM_CH = 4;

  // Register byte addresses
  localparam logic [7:0] ADDR_CHANNEL_CONTROL   = 8'hD4;
  localparam logic [7:0] ADDR_EVENT_FLAGS       = 8'hD5 + 8'h03;
  localparam logic [7:0] ADDR_CHANNEL_SELECTOR  = 8'hDC;
  localparam logic [7:0] ADDR_CHANNEL_DATA      = 8'hE0;
  localparam logic [7:0] ADDR_TIMER_STATUS      = 8'hE4;
  localparam logic [7:0] ADDR_TIMER_CONFIG      = 8'hE8;

  // Field positions of channel_control
  localparam int BIT_IRQ_EN   = 7;
  localparam int BIT_DIR      = 6;
  localparam int BIT_RSVD     = 5;
  localparam int BIT_CLR_TMR  = 4;
  localparam int BIT_CMP_SEL  = 3;
  localparam int SEL_MSB      = 2;

  // Fixed value returned for the reserved bit
  localparam logic RSVD_READ = 1'b0;

  // Reset values
  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  localparam logic [15:0] DATA_RESET  = 16'h0000;
  localparam logic [15:0] TIMER_CLEAR = 16'h0000;

  // Timer config fields
  localparam int BIT_CAP_RELOAD = 0;
  localparam int BIT_MODE_HI    = 2;
  localparam int BIT_ARRAY_IEN  = 3;

  // Capture event selector codes
  typedef enum logic [2:0] {
    EV_OFF, EV_FALL, EV_RISE, EV_BOTH, EV_T0OVF, EV_T1OVF, EV_CMPA, EV_CMPB
  } event_sel_e;
endpackage

// ### src/cca_channel.sv
/*
  One compare/capture channel: control fields, event decode, data register.
  Assumes the pin is synchronous and held for two clocks by the source.
*/
`timescale 1ns/1ps
`default_nettype none
module cca_channel
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Register access
  input  wire logic        ctrl_we,
  input  wire logic [7:0]  ctrl_wdata,
  input  wire logic        data_we,
  input  wire logic [15:0] data_wdata,
  // Event sources
  input  wire logic        pin,
  input  wire logic        t0_ovf,
  input  wire logic        t1_ovf,
  input  wire logic        cmpa_ev,
  input  wire logic        cmpb_ev,
  input  wire logic [15:0] timer_count,
  input  wire logic        dual_slope,
  input  wire logic        count_down,
  // Results
  output logic      [7:0]  ctrl_q,
  output logic      [15:0] data_q,
  output logic             event_o
);
  logic       pin_q;
  logic       fall;
  logic       rise;
  logic       cap_ev;
  logic       cmp_ev;
  logic [2:0] sel;

  assign sel  = ctrl_q[cca_pkg::SEL_MSB:0];
  assign fall = pin_q & ~pin;
  assign rise = ~pin_q & pin;

  always_comb
  begin
    cap_ev = 1'b0;
    unique case (cca_pkg::event_sel_e'(sel))
      cca_pkg::EV_OFF:   cap_ev = 1'b0;
      cca_pkg::EV_FALL:  cap_ev = fall;
      cca_pkg::EV_RISE:  cap_ev = rise;
      cca_pkg::EV_BOTH:  cap_ev = fall | rise;
      cca_pkg::EV_T0OVF: cap_ev = t0_ovf;
      cca_pkg::EV_T1OVF: cap_ev = t1_ovf;
      cca_pkg::EV_CMPA:  cap_ev = cmpa_ev;
      cca_pkg::EV_CMPB:  cap_ev = cmpb_ev;
    endcase
  end

  // Captures run in any timer mode; only the count range differs
  assign cmp_ev  = (data_q == timer_count);
  assign event_o = ctrl_q[cca_pkg::BIT_CMP_SEL] ? cmp_ev : cap_ev;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_q <= 1'b0;
    else
      pin_q <= pin;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_q <= cca_pkg::CTRL_RESET;
    else
    begin
      if (ctrl_we)
      begin
        // Direction and reserved bits keep their value
        ctrl_q[7] <= ctrl_wdata[7];
        ctrl_q[4:0] <= ctrl_wdata[4:0];
      end
      if (event_o && dual_slope)
        ctrl_q[cca_pkg::BIT_DIR] <= count_down;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      data_q <= cca_pkg::DATA_RESET;
    else if (cap_ev && !ctrl_q[cca_pkg::BIT_CMP_SEL])
      data_q <= timer_count;
    else if (data_we)
      data_q <= data_wdata;
  end
endmodule
`default_nettype wire

// ### src/cca_capture_channel_control.sv
/*
  Four-channel compare/capture control with APB register access.
  Assumes timer count, direction, overflow and trigger events arrive as
  synchronous inputs; the timer clear request goes back to the timer.
*/
// Notes on behaviour
// - Captures run in the capture timer setup and in any other timer mode.
// - The timer overflow flag is readable next to captured data.
// - In dual-slope mode the count direction is stored on each event.
// - Both event kinds update the direction bit; writes to it are ignored.
// - With clear-on-event set, an event clears the timer, otherwise not.
// - Mode select 1 means compare, 0 means capture.
// - Selector 000 off, 001 falling, 010 rising, 011 either pin edge.
// - A capture copies the timer count and sets the channel event flag.
// - A flag interrupts only with channel and array enable; software clears.
// - Selector 100 T0 ovf, 101 T1 ovf, 110 comparator A, 111 comparator B.
// - Control access reaches only the channel named by the selector.
`timescale 1ns/1ps
`default_nettype none
module cca_capture_channel_control
(
  // APB
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Pins and triggers
  input  wire logic [3:0]  channel_input_pin,
  input  wire logic        t0_ovf,
  input  wire logic        t1_ovf,
  input  wire logic        cmpa_ev,
  input  wire logic        cmpb_ev,
  // Timer
  input  wire logic [7:0]  timer_count_low,
  input  wire logic [7:0]  timer_count_high,
  input  wire logic        timer_overflow_flag,
  input  wire logic        timer_count_down,
  output logic             timer_clear,
  output logic             timer_capture_reload_sel,
  output logic      [1:0]  timer_count_mode,
  // Interrupt request
  output logic             cca_irq
);
  logic [1:0]  channel_selector_q;
  logic [3:0]  event_flag_register_q;
  logic        array_irq_en_q;
  logic [7:0]  ctrl   [cca_pkg::NUM_CH];
  logic [15:0] data   [cca_pkg::NUM_CH];
  logic [3:0]  ev;
  logic [3:0]  ctrl_we;
  logic [3:0]  data_we;
  logic [3:0]  clr_req;
  logic [3:0]  irq_src;
  logic        wr;
  logic        acc;
  logic        dual_slope;
  logic        known;
  logic [7:0]  ctrl_rd;
  logic [15:0] tcount;

  assign tcount = {timer_count_high, timer_count_low};
  assign acc    = psel & penable;
  assign wr     = acc & pwrite;
  assign dual_slope = ~timer_capture_reload_sel
                      & timer_count_mode[1];

  genvar g;
  generate
    for (g = 0; g < cca_pkg::NUM_CH; g++)
    begin : g_ch
      assign ctrl_we[g] = wr && paddr == cca_pkg::ADDR_CHANNEL_CONTROL
                          && channel_selector_q == 2'(g);
      assign data_we[g] = wr && paddr == cca_pkg::ADDR_CHANNEL_DATA
                          && channel_selector_q == 2'(g);
      assign clr_req[g] = ev[g] & ctrl[g][cca_pkg::BIT_CLR_TMR];
      assign irq_src[g] = event_flag_register_q[g]
                          & ctrl[g][cca_pkg::BIT_IRQ_EN];
      cca_channel u_ch
      (
        .pclk        (pclk),
        .presetn     (presetn),
        .ctrl_we     (ctrl_we[g]),
        .ctrl_wdata  (pwdata[7:0]),
        .data_we     (data_we[g]),
        .data_wdata  (pwdata[15:0]),
        .pin         (channel_input_pin[g]),
        .t0_ovf      (t0_ovf),
        .t1_ovf      (t1_ovf),
        .cmpa_ev     (cmpa_ev),
        .cmpb_ev     (cmpb_ev),
        .timer_count (tcount),
        .dual_slope  (dual_slope),
        .count_down  (timer_count_down),
        .ctrl_q      (ctrl[g]),
        .data_q      (data[g]),
        .event_o     (ev[g])
      );
    end
  endgenerate

  // Fixed reserved bit on read
  always_comb
  begin
    ctrl_rd = ctrl[channel_selector_q];
    ctrl_rd[cca_pkg::BIT_RSVD] = cca_pkg::RSVD_READ;
  end

  always_comb
  begin
    known = 1'b1;
    unique case (paddr)
      cca_pkg::ADDR_CHANNEL_CONTROL,
      cca_pkg::ADDR_EVENT_FLAGS,
      cca_pkg::ADDR_CHANNEL_SELECTOR,
      cca_pkg::ADDR_CHANNEL_DATA,
      cca_pkg::ADDR_TIMER_STATUS,
      cca_pkg::ADDR_TIMER_CONFIG: known = 1'b1;
      default: known = 1'b0;
    endcase
  end

  // Zero wait states; unmapped addresses answer with an error
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~known;
    end
  end

  // Writes clear it too, so an error answer never carries stale data
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable)
    begin
      prdata <= 32'h0000_0000;
      if (!pwrite)
      begin
        unique case (paddr)
          cca_pkg::ADDR_CHANNEL_CONTROL:
            prdata[7:0] <= ctrl_rd;
          cca_pkg::ADDR_EVENT_FLAGS:
            prdata[3:0] <= event_flag_register_q;
          cca_pkg::ADDR_CHANNEL_SELECTOR:
            prdata[1:0] <= channel_selector_q;
          cca_pkg::ADDR_CHANNEL_DATA:
            prdata[15:0] <= data[channel_selector_q];
          cca_pkg::ADDR_TIMER_STATUS:
            prdata[0] <= timer_overflow_flag;
          cca_pkg::ADDR_TIMER_CONFIG:
            prdata[3:0] <= {array_irq_en_q, timer_count_mode,
                            timer_capture_reload_sel};
          default:
            prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Register updates land on the access edge, matching pready
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      channel_selector_q <= 2'h0;
    else if (wr && pready && paddr == cca_pkg::ADDR_CHANNEL_SELECTOR)
      channel_selector_q <= pwdata[1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_capture_reload_sel <= 1'b0;
      timer_count_mode         <= 2'h0;
      array_irq_en_q           <= 1'b0;
    end
    else if (wr && pready && paddr == cca_pkg::ADDR_TIMER_CONFIG)
    begin
      timer_capture_reload_sel <= pwdata[cca_pkg::BIT_CAP_RELOAD];
      timer_count_mode         <= pwdata[cca_pkg::BIT_MODE_HI:1];
      array_irq_en_q           <= pwdata[cca_pkg::BIT_ARRAY_IEN];
    end
  end

  // Flags: write 1 clears; a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      event_flag_register_q <= 4'h0;
    else if (wr && pready && paddr == cca_pkg::ADDR_EVENT_FLAGS)
      event_flag_register_q <= (event_flag_register_q & ~pwdata[3:0])
                               | ev;
    else
      event_flag_register_q <= event_flag_register_q | ev;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_clear <= 1'b0;
      cca_irq     <= 1'b0;
    end
    else
    begin
      timer_clear <= |clr_req;
      cca_irq     <= array_irq_en_q & (|irq_src);
    end
  end
endmodule
`default_nettype wire

// ### tb/cca_asserts.sv
/* Checker on the top ports: APB timing and register reads.
   Assumes the bench holds the overflow flag steady around reads. */
`timescale 1ns/1ps
`default_nettype none
module cca_asserts
(
  // APB
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Timer
  input wire logic        timer_overflow_flag,
  input wire logic        timer_capture_reload_sel,
  input wire logic [1:0]  timer_count_mode
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [31:0] wd_q;
  logic        cfg_wr;
  always_ff @(posedge pclk)
    wd_q <= pwdata;
  assign cfg_wr = pready && pwrite && paddr == cca_pkg::ADDR_TIMER_CONFIG;
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence rd_s(a);
    pready && !pwrite && paddr == a;
  endsequence
  setup_ready_a: assert property (setup_s |=> pready && penable)
    else $error("no answer after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  error_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error carries data");
  config_write_a: assert property (cfg_wr |=>
    timer_capture_reload_sel == wd_q[0] && timer_count_mode == wd_q[2:1])
    else $error("config not taken");
  config_hold_a: assert property (
    !cfg_wr |=> $stable(timer_count_mode))
    else $error("config moved");
  status_read_a: assert property (rd_s(cca_pkg::ADDR_TIMER_STATUS) |->
    prdata == {31'h0, $past(timer_overflow_flag)})
    else $error("overflow flag wrong");
  reserved_read_a: assert property (
    rd_s(cca_pkg::ADDR_CHANNEL_CONTROL) |->
    prdata[31:8] == 24'h0 && prdata[5] == cca_pkg::RSVD_READ)
    else $error("reserved bit wrong");
endmodule
bind cca_capture_channel_control cca_asserts chk_u
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr),
  .timer_overflow_flag(timer_overflow_flag),
  .timer_capture_reload_sel(timer_capture_reload_sel),
  .timer_count_mode(timer_count_mode)
);
`default_nettype wire

// ### tb/timer_model.sv
/* Timer model: 16-bit up counter, cleared on request.
   Assumes the bench stops it with run low before comparing counts. */
`timescale 1ns/1ps
`default_nettype none
module timer_model
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control
  input  wire logic       run,
  input  wire logic       clear,
  // Count
  output logic      [7:0] count_low,
  output logic      [7:0] count_high
);
  logic [15:0] cnt_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_q <= 16'h0000;
    else if (clear)
      cnt_q <= 16'h0000;
    else if (run)
      cnt_q <= cnt_q + 16'h0001;
  end
  assign count_low = cnt_q[7:0];
  assign count_high = cnt_q[15:8];
endmodule
`default_nettype wire

// ### tb/tb_top.sv
/* Bench for the channel control block.
   Assumes the timer model stands in for the timer. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, tclr, crs, irq, err_q;
  logic [1:0]  cmode;
  logic [3:0]  pin = 4'h0;
  logic [3:0]  trg = 4'h0;
  logic [7:0]  lo, hi;
  logic        ovf = 1'b0;
  logic        down = 1'b0;
  logic        run = 1'b1;
  int          failures = 0;
  int          checks = 0;
  int          cycles = 0;
  always #2.5 pclk = ~pclk;
  cca_capture_channel_control dut_u
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .channel_input_pin(pin),
    .t0_ovf(trg[0]), .t1_ovf(trg[1]), .cmpa_ev(trg[2]), .cmpb_ev(trg[3]),
    .timer_count_low(lo), .timer_count_high(hi),
    .timer_overflow_flag(ovf), .timer_count_down(down),
    .timer_clear(tclr), .timer_capture_reload_sel(crs),
    .timer_count_mode(cmode), .cca_irq(irq)
  );
  timer_model tmr_u
  (
    .pclk(pclk), .presetn(presetn), .run(run), .clear(tclr),
    .count_low(lo), .count_high(hi)
  );
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      failures++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Called just after a rising edge; answer sampled at the access edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Ends when pready is high; if pready never rises, only the bench timeout ends this wait
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so the next call never redrives psel in this time step
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  task automatic t_regs();
    rd(cca_pkg::ADDR_CHANNEL_CONTROL, 32'h0);
    wr(cca_pkg::ADDR_CHANNEL_CONTROL, 32'hFF);
    rd(cca_pkg::ADDR_CHANNEL_CONTROL, 32'h9F);
    wr(cca_pkg::ADDR_CHANNEL_SELECTOR, 32'h1);
    rd(cca_pkg::ADDR_CHANNEL_CONTROL, 32'h0);
    wr(cca_pkg::ADDR_CHANNEL_SELECTOR, 32'h0);
    rd(8'h00, 32'h0);
    chk({31'h0, err_q}, 32'h1);
    ovf <= 1'b1;
    rd(cca_pkg::ADDR_TIMER_STATUS, 32'h1);
    $display("t_regs done");
  endtask
  task automatic t_codes();
    logic [15:0] c;
    run <= 1'b0;
    wr(cca_pkg::ADDR_TIMER_CONFIG, 32'h9);
    c = {hi, lo};
    for (int k = 0; k < 8; k++)
    begin
      wr(cca_pkg::ADDR_CHANNEL_CONTROL, 32'h80 | k);
      wr(cca_pkg::ADDR_EVENT_FLAGS, 32'hF);
      if (k < 4)
        pin[0] <= 1'b1;
      else
        trg[k-4] <= 1'b1;
      @(posedge pclk);
      trg <= 4'h0;
      repeat (3) @(posedge pclk);
      chk({31'h0, irq}, {31'h0, k > 1});
      rd(cca_pkg::ADDR_EVENT_FLAGS, {31'h0, k > 1});
      if (k > 1)
        rd(cca_pkg::ADDR_CHANNEL_DATA, {16'h0, c});
      wr(cca_pkg::ADDR_EVENT_FLAGS, 32'hF);
      pin[0] <= 1'b0;
      repeat (4) @(posedge pclk);
      rd(cca_pkg::ADDR_EVENT_FLAGS, {31'h0, k == 1 || k == 3});
    end
    chk({31'h0, irq}, 32'h0);
    chk({16'h0, hi, lo}, {16'h0, c});
    $display("t_codes done");
  endtask
  task automatic t_dir();
    wr(cca_pkg::ADDR_TIMER_CONFIG, 32'hC);
    down <= 1'b1;
    wr(cca_pkg::ADDR_CHANNEL_CONTROL, 32'h92);
    pin[0] <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(cca_pkg::ADDR_CHANNEL_CONTROL, 32'hD2);
    chk({16'h0, hi, lo}, 32'h0);
    down <= 1'b0;
    pin[0] <= 1'b0;
    wr(cca_pkg::ADDR_EVENT_FLAGS, 32'hF);
    wr(cca_pkg::ADDR_CHANNEL_DATA, 32'h40);
    wr(cca_pkg::ADDR_CHANNEL_CONTROL, 32'h18);
    run <= 1'b1;
    repeat (100) @(posedge pclk);
    run <= 1'b0;
    rd(cca_pkg::ADDR_EVENT_FLAGS, 32'h1);
    rd(cca_pkg::ADDR_CHANNEL_CONTROL, 32'h18);
    chk({31'h0, {hi, lo} < 16'h0041}, 32'h1);
    $display("t_dir done");
  endtask
  // Whole run is well under a thousand cycles
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      stop_test();
    end
  end
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_codes();
    t_dir();
    stop_test();
  end
endmodule
`default_nettype wire
